// >>> testbench/hss_host_model.sv
// host-side serial master model driving the switch link
`timescale 1ns/1ps
module hss_host_model (
   // link pins
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   // ------------------------------------------------------------
   // frame driver
   // ------------------------------------------------------------
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // clock stands still outside frames; the last n bits sampled land in rx
   task automatic xfer(input int n, input logic [63:0] d, output logic [63:0] rx, output logic oe);
      rx = '0;
      cs_n = 1'b0;
      #200;
      oe = so_oe;
      for (int k = n - 1; k >= 0; k--) begin
         si = d[k];
         #6;
         rx = {rx[62:0], so_o};
         oe = oe & so_oe;
         sclk = 1'b1;
         #6;
         sclk = 1'b0;
      end
      #20;
      cs_n = 1'b1;
      // released line: no stale level
      si = ~si;
      #200;
   endtask
endmodule

// >>> testbench/tb_switch_spi_config_and_status.sv
// self-checking bench of the switch serial configuration block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_switch_spi_config_and_status
   import hss_pkg::*;
;
   // ------------------------------------------------------------
   // signals and reference state
   // ------------------------------------------------------------
   localparam int TK = 4;
   logic sys_clk, rst, sclk, cs_n, si, so_o, so_oe, wake_pin, uv_event, ov_event;
   logic [3:0] direct_in, fault_summary, switch_on, sense_ratio_high, fast_slew_select, thermal_latch_en;
   logic undervoltage_disable, overvoltage_disable, watchdog_timeout;
   logic [15:0] fault_detail;
   int n_errors = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h1032;
   logic [31:0] r;
   logic [63:0] d;
   logic [4:0] a;
   logic [3:0] onoff, sot, watchdog_overtemp_config;
   logic [3:0] direct_input_config [4];
   logic [4:0] sel, paddr;
   logic pwd, uvf, ovf, ign, wto;
   logic [4:0] tbl [5] = '{ADDR_ONOFF, ADDR_SUPPLY_OT, ADDR_WATCHDOG, ADDR_NO_OP, 5'h04};
   int lens [6] = '{0, 15, 17, 32, 33, 48};
   int ms [4] = '{558, 279, 2250, 1125};

   hss_spi_config #(.TICK_CYCLES_P(TK)) dut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si),
      .so_o(so_o), .so_oe(so_oe), .direct_in(direct_in), .wake_pin(wake_pin), .uv_event(uv_event),
      .ov_event(ov_event), .fault_summary(fault_summary), .fault_detail(fault_detail), .switch_on(switch_on),
      .sense_ratio_high(sense_ratio_high), .fast_slew_select(fast_slew_select),
      .undervoltage_disable(undervoltage_disable), .overvoltage_disable(overvoltage_disable),
      .thermal_latch_en(thermal_latch_en), .watchdog_timeout(watchdog_timeout));
   hss_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe(so_oe));

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // always toggles against the last accepted bit, so the watchdog restarts
   function automatic logic [63:0] mk(input logic [4:0] ad, input logic [4:0] v);
      return {48'h0, ~pwd, 2'h0, ad, 3'h0, v};
   endfunction

   function automatic logic [3:0] rb();
      logic [1:0] s;
      s = sel[4:3];
      if (sel[2:0] == 3'h0) return fault_detail[4*s +: 4];
      if (sel[2:0] == 3'h4) return direct_input_config[s];
      case (sel)
         5'h01: return onoff;
         5'h05: return sot;
         5'h0d: return {1'b0, wto, watchdog_overtemp_config[1:0]};
         5'h06: return {3'h1, wake_pin};
         5'h0e: return direct_in;
         5'h0f: return {watchdog_overtemp_config[3:2], 2'h0};
         default: return 4'h0;
      endcase
   endfunction

   task automatic outs();
      logic [3:0] sw, fs, sr;
      for (int s = 0; s < 4; s++) begin
         fs[s] = direct_input_config[s][3];
         sr[s] = direct_input_config[s][2];
         sw[s] = direct_input_config[s][1] ? onoff[s] : (direct_input_config[s][0] ? onoff[s] & direct_in[s] : onoff[s] | direct_in[s]);
      end
      `CHK(switch_on, sw)
      `CHK(sense_ratio_high, sr)
      `CHK(fast_slew_select, fs)
      `CHK({undervoltage_disable, overvoltage_disable}, sot[1:0])
      `CHK(thermal_latch_en, {{2{~&watchdog_overtemp_config[3:2]}}, {2{~&sot[3:2]}}})
      `CHK(watchdog_timeout, 1'b0)
   endtask

   task automatic send(input int n, input logic [63:0] dd);
      logic [63:0] rx, ex;
      logic oe;
      logic [15:0] m, rt;
      rt = {pwd, uvf, ovf, paddr, fault_summary, rb()};
      ex = (n >= 16) ? ((64'(rt) << (n - 16)) | (dd >> 16)) : 64'(rt >> (16 - n));
      host.xfer(n, dd, rx, oe);
      if (!ign) `CHK(rx, ex)
      `CHK(oe, 1'b1)
      `CHK(so_oe, 1'b0)
      m = dd[15:0];
      if (n > 0 && n % 16 == 0) begin
         // only a toggled watchdog bit clears the expected timeout
         if (m[15] != pwd) wto = 1'b0;
         pwd = m[15];
         paddr = m[12:8];
         uvf = 1'b0;
         ovf = 1'b0;
         if (m[12:8] == ADDR_STATUS_SEL) sel = m[4:0];
         if (m[12:8] == ADDR_ONOFF) onoff = m[3:0];
         if (m[10:8] == CODE_DIRECT_IN) direct_input_config[m[12:11]] = m[3:0];
         if (m[12:8] == ADDR_SUPPLY_OT) sot = m[3:0];
         if (m[12:8] == ADDR_WATCHDOG) watchdog_overtemp_config = m[3:0];
      end
      repeat (8) @(negedge sys_clk);
      outs();
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // whole run is under one millisecond
   initial begin
      #3_000_000;
      n_errors++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      {direct_in, wake_pin, uv_event, ov_event, fault_summary, fault_detail} = '0;
      {onoff, sot, watchdog_overtemp_config, sel, paddr, pwd, uvf, ovf, wto} = '0;
      for (int s = 0; s < 4; s++) direct_input_config[s] = 4'h0;
      ign = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      outs();
      send(16, mk(ADDR_NO_OP, 5'h00)); // first return after reset is not judged
      ign = 1'b0;
      for (int i = 0; i < 128; i++) begin
         r = rnd();
         {direct_in, wake_pin, fault_summary, uv_event, ov_event} = r[10:0];
         fault_detail = r[31:16];
         @(negedge sys_clk);
         uv_event = 1'b0;
         ov_event = 1'b0;
         // events sit in the two low bits of the random word
         uvf |= r[1];
         ovf |= r[0];
         repeat (4) @(negedge sys_clk);
         a = tbl[r[13:11] % 5];
         if (a == 5'h04) a[4:3] = r[15:14];
         if (i % 4 == 0) send(16, mk(ADDR_STATUS_SEL, 5'(i / 4)));
         else send(16, mk(a, {1'b0, r[31:28]}));
      end
      foreach (lens[j]) begin
         r = rnd();
         d = (({r, r} << 16) | mk(ADDR_ONOFF, {1'b0, r[3:0]})) & ((64'h1 << lens[j]) - 64'h1);
         send(lens[j], d);
      end
      send(16, mk(ADDR_STATUS_SEL, ADDR_WATCHDOG));
      for (int c = 0; c < 4; c++) begin
         send(16, mk(ADDR_WATCHDOG, 5'(c)));
         repeat (ms[c] * TK - 60) @(negedge sys_clk);
         `CHK(watchdog_timeout, 1'b0)
         repeat (100) @(negedge sys_clk);
         `CHK(watchdog_timeout, 1'b1)
         wto = 1'b1;
         send(16, mk(ADDR_NO_OP, 5'h1f));
      end
      print_verdict();
   end
endmodule

// >>> verilog/hss_pkg.sv
// shared constants and carriers for the switch serial configuration block
package hss_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int NS_PER_S = 1_000_000_000;
   localparam int CLK_PERIOD_NS = NS_PER_S / CLK_HZ;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = (TICK_MS * 1_000_000) / CLK_PERIOD_NS;
   localparam int TICK_W = 16;
   localparam int WD_MS_W = 12;
   localparam logic [WD_MS_W-1:0] WD_MS_00 = 12'd558;
   localparam logic [WD_MS_W-1:0] WD_MS_01 = 12'd279;
   localparam logic [WD_MS_W-1:0] WD_MS_10 = 12'd2250;
   localparam logic [WD_MS_W-1:0] WD_MS_11 = 12'd1125;

   // ------------------------------------------------------------
   // frame and address codes
   // ------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int CNT_W = 4;
   localparam int N_OUT = 4;
   localparam logic [4:0] ADDR_STATUS_SEL = 5'h00;
   localparam logic [4:0] ADDR_ONOFF = 5'h01;
   localparam logic [4:0] ADDR_SUPPLY_OT = 5'h05;
   localparam logic [4:0] ADDR_NO_OP = 5'h06;
   localparam logic [4:0] ADDR_WATCHDOG = 5'h0d;
   localparam logic [2:0] CODE_DIRECT_IN = 3'h4;
   localparam logic [2:0] CODE_FAULT = 3'h0;
   localparam logic [4:0] RB_PIN_STATE = 5'h0e;
   localparam logic [4:0] RB_OT_23 = 5'h0f;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int SOT_OVERVOLTAGE_DISABLE = 0;
   localparam int SOT_UNDERVOLTAGE_DISABLE = 1;
   localparam int SOT_LATCH0 = 2;
   localparam int SOT_LATCH1 = 3;
   localparam int WDR_LATCH2 = 2;
   localparam int WDR_LATCH3 = 3;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam logic [4:0] SEL_RESET = 5'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic fast_slew;
      logic sense_high;
      logic pin_disable;
      logic and_mode;
   } hss_direct_input_config_t;

   typedef struct packed {
      logic wd;
      logic [1:0] zero_hi;
      logic [1:0] osel;
      logic [2:0] code;
      logic [2:0] zero_lo;
      logic d4;
      logic [3:0] data;
   } hss_msg_t;

   typedef struct packed {
      logic wd;
      logic uv;
      logic ov;
      logic [4:0] addr;
      logic [3:0] fault;
      logic [3:0] data;
   } hss_ret_t;

   typedef enum logic {
      HSS_IDLE,
      HSS_FRAME
   } hss_frame_t;

endpackage

// >>> verilog/hss_spi_config.sv
// serial configuration and status block of the quad switch
`timescale 1ns/1ps
module hss_spi_config
   import hss_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
   // system
   input wire logic sys_clk,
   input wire logic rst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // direct input pins and wake pin
   input wire logic [N_OUT-1:0] direct_in,
   input wire logic wake_pin,
   // protection and fault reports, same clock
   input wire logic uv_event,
   input wire logic ov_event,
   input wire logic [N_OUT-1:0] fault_summary,
   input wire logic [4*N_OUT-1:0] fault_detail,
   // switch controls
   output logic [N_OUT-1:0] switch_on,
   output logic [N_OUT-1:0] sense_ratio_high,
   output logic [N_OUT-1:0] fast_slew_select,
   output logic undervoltage_disable,
   output logic overvoltage_disable,
   output logic [N_OUT-1:0] thermal_latch_en,
   output logic watchdog_timeout
);

   // ------------------------------------------------------------
   // link side
   // ------------------------------------------------------------
   hss_ret_t ret_q, ret_d;
   logic [WORD_BITS-1:0] rx_word;
   logic len_ok;
   logic frame_tgl;

   hss_spi_link u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .si(si),
      .so_o(so_o),
      .so_oe(so_oe),
      .rst(rst),
      .ret_word(ret_q),
      .rx_word(rx_word),
      .len_ok(len_ok),
      .frame_tgl(frame_tgl)
   );

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   logic cs_s1_q, cs_s2_q;
   logic tgl_s1_q, tgl_s2_q;
   logic [N_OUT-1:0] pin_s1_q, pin_s2_q;
   logic wake_s1_q, wake_s2_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else begin
         cs_s1_q <= cs_n;
         cs_s2_q <= cs_s1_q;
         tgl_s1_q <= frame_tgl;
         tgl_s2_q <= tgl_s1_q;
         pin_s1_q <= direct_in;
         pin_s2_q <= pin_s1_q;
         wake_s1_q <= wake_pin;
         wake_s2_q <= wake_s1_q;
      end
   end

   // ------------------------------------------------------------
   // frame tracking and message decode
   // ------------------------------------------------------------
   hss_frame_t state_q, state_d;
   logic seen_tgl_q, seen_tgl_d;
   logic frame_end;
   logic commit;
   hss_msg_t msg;
   logic [4:0] addr;

   assign msg = rx_word;
   assign addr = {msg.osel, msg.code};
   // word and length flag are quiet once the serial clock has stopped
   assign frame_end = (state_q == HSS_FRAME) && cs_s2_q;
   assign commit = frame_end && len_ok && (tgl_s2_q != seen_tgl_q);

   always_comb begin
      state_d = state_q;
      seen_tgl_d = seen_tgl_q;
      case (state_q)
         HSS_IDLE: begin
            if (!cs_s2_q) begin
               state_d = HSS_FRAME;
            end
         end
         HSS_FRAME: begin
            if (cs_s2_q) begin
               state_d = HSS_IDLE;
               seen_tgl_d = tgl_s2_q;
            end
         end
         default: begin
            state_d = HSS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= HSS_IDLE;
         seen_tgl_q <= 1'b0;
      end else begin
         state_q <= state_d;
         seen_tgl_q <= seen_tgl_d;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   hss_direct_input_config_t direct_input_config_q [N_OUT];
   hss_direct_input_config_t direct_input_config_d [N_OUT];
   logic [3:0] onoff_q, onoff_d;
   logic [3:0] sot_q, sot_d;
   logic [3:0] wdr_q, wdr_d;
   logic [4:0] sel_q, sel_d;
   logic [4:0] prev_addr_q, prev_addr_d;
   logic prev_wd_q, prev_wd_d;
   logic uv_q, uv_d;
   logic ov_q, ov_d;

   always_comb begin
      direct_input_config_d = direct_input_config_q;
      onoff_d = onoff_q;
      sot_d = sot_q;
      wdr_d = wdr_q;
      sel_d = sel_q;
      prev_addr_d = prev_addr_q;
      prev_wd_d = prev_wd_q;
      // flags clear on each accepted frame; a new event in that cycle still sets
      uv_d = (uv_q & ~commit) | uv_event;
      ov_d = (ov_q & ~commit) | ov_event;
      if (commit) begin
         prev_addr_d = addr;
         prev_wd_d = msg.wd;
         if (addr == ADDR_STATUS_SEL) begin
            sel_d = {msg.d4, msg.data};
         end else if (addr == ADDR_ONOFF) begin
            onoff_d = msg.data;
         end else if (msg.code == CODE_DIRECT_IN) begin
            direct_input_config_d[msg.osel] = msg.data;
         end else if (addr == ADDR_SUPPLY_OT) begin
            sot_d = msg.data;
         end else if (addr == ADDR_WATCHDOG) begin
            wdr_d = msg.data;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < N_OUT; i++) begin
            direct_input_config_q[i] <= CFG_RESET;
         end
         onoff_q <= CFG_RESET;
         sot_q <= CFG_RESET;
         wdr_q <= CFG_RESET;
         sel_q <= SEL_RESET;
         prev_addr_q <= 5'h00;
         prev_wd_q <= 1'b0;
         uv_q <= 1'b0;
         ov_q <= 1'b0;
      end else begin
         direct_input_config_q <= direct_input_config_d;
         onoff_q <= onoff_d;
         sot_q <= sot_d;
         wdr_q <= wdr_d;
         sel_q <= sel_d;
         prev_addr_q <= prev_addr_d;
         prev_wd_q <= prev_wd_d;
         uv_q <= uv_d;
         ov_q <= ov_d;
      end
   end

   // ------------------------------------------------------------
   // watchdog, counted in millisecond ticks
   // ------------------------------------------------------------
   logic [TICK_W-1:0] tick_q, tick_d;
   logic [WD_MS_W-1:0] ms_q, ms_d;
   logic [WD_MS_W-1:0] wd_limit;
   logic wdto_q, wdto_d;
   logic wd_restart;

   assign wd_restart = commit && (msg.wd != prev_wd_q);

   always_comb begin
      case (wdr_q[1:0])
         2'b00: wd_limit = WD_MS_00;
         2'b01: wd_limit = WD_MS_01;
         2'b10: wd_limit = WD_MS_10;
         default: wd_limit = WD_MS_11;
      endcase
      tick_d = tick_q + 16'h0001;
      ms_d = ms_q;
      wdto_d = wdto_q;
      if (tick_q == TICK_W'(TICK_CYCLES_P - 1)) begin
         tick_d = 16'h0000;
         if (!wdto_q) begin
            ms_d = ms_q + 12'h001;
         end
      end
      if (ms_q >= wd_limit) begin
         wdto_d = 1'b1;
      end
      // a new period takes effect on a fresh count when the toggle comes with it
      if (wd_restart) begin
         tick_d = 16'h0000;
         ms_d = 12'h000;
         wdto_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tick_q <= 16'h0000;
         ms_q <= 12'h000;
         wdto_q <= 1'b0;
      end else begin
         tick_q <= tick_d;
         ms_q <= ms_d;
         wdto_q <= wdto_d;
      end
   end

   // ------------------------------------------------------------
   // return word, frozen while a frame is under way
   // ------------------------------------------------------------
   logic [3:0] rb_data;
   logic [1:0] rb_sel;

   assign rb_sel = sel_q[4:3];

   always_comb begin
      rb_data = 4'h0;
      if (sel_q[2:0] == CODE_FAULT) begin
         rb_data = fault_detail[4*rb_sel +: 4];
      end else if (sel_q[2:0] == CODE_DIRECT_IN) begin
         rb_data = direct_input_config_q[rb_sel];
      end else if (sel_q == ADDR_ONOFF) begin
         rb_data = onoff_q;
      end else if (sel_q == ADDR_SUPPLY_OT) begin
         rb_data = sot_q;
      end else if (sel_q == ADDR_WATCHDOG) begin
         rb_data = {1'b0, wdto_q, wdr_q[1:0]};
      end else if (sel_q == ADDR_NO_OP) begin
         rb_data = {3'h1, wake_s2_q};
      end else if (sel_q == RB_PIN_STATE) begin
         rb_data = pin_s2_q;
      end else if (sel_q == RB_OT_23) begin
         rb_data = {wdr_q[WDR_LATCH3], wdr_q[WDR_LATCH2], 2'h0};
      end
      ret_d = ret_q;
      // fault capture only between frames
      if (cs_s2_q && state_q == HSS_IDLE) begin
         ret_d = {prev_wd_q, uv_q, ov_q, prev_addr_q, fault_summary, rb_data};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ret_q <= 16'h0000;
      end else begin
         ret_q <= ret_d;
      end
   end

   // ------------------------------------------------------------
   // switch controls
   // ------------------------------------------------------------
   logic [N_OUT-1:0] sw_q, sw_d;

   for (genvar g = 0; g < N_OUT; g++) begin : g_out
      always_comb begin
         if (direct_input_config_q[g].pin_disable) begin
            sw_d[g] = onoff_q[g];
         end else if (direct_input_config_q[g].and_mode) begin
            sw_d[g] = pin_s2_q[g] & onoff_q[g];
         end else begin
            sw_d[g] = pin_s2_q[g] | onoff_q[g];
         end
      end
      assign sense_ratio_high[g] = direct_input_config_q[g].sense_high;
      assign fast_slew_select[g] = direct_input_config_q[g].fast_slew;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sw_q <= 4'h0;
      end else begin
         sw_q <= sw_d;
      end
   end

   assign switch_on = sw_q;
   assign undervoltage_disable = sot_q[SOT_UNDERVOLTAGE_DISABLE];
   assign overvoltage_disable = sot_q[SOT_OVERVOLTAGE_DISABLE];
   // mixed latch codes keep latching, the safer reading
   assign thermal_latch_en[0] = ~(sot_q[SOT_LATCH0] & sot_q[SOT_LATCH1]);
   assign thermal_latch_en[1] = ~(sot_q[SOT_LATCH0] & sot_q[SOT_LATCH1]);
   assign thermal_latch_en[2] = ~(wdr_q[WDR_LATCH2] & wdr_q[WDR_LATCH3]);
   assign thermal_latch_en[3] = ~(wdr_q[WDR_LATCH2] & wdr_q[WDR_LATCH3]);
   assign watchdog_timeout = wdto_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_pin_ignored: assert property (
      direct_input_config_q[0].pin_disable && $stable(onoff_q) |=> switch_on[0] == $past(onoff_q[0]))
      else $error("pin not ignored while disabled");
   chk_and_combine: assert property (
      !direct_input_config_q[1].pin_disable && direct_input_config_q[1].and_mode && !pin_s2_q[1] |=> !switch_on[1])
      else $error("and combine not applied");
   chk_ratio_write: assert property (
      commit && msg.code == CODE_DIRECT_IN |=> sense_ratio_high[$past(msg.osel)] == $past(msg.data[2]))
      else $error("sense ratio not written");
   chk_uv_disable: assert property (
      commit && addr == ADDR_SUPPLY_OT |=> undervoltage_disable == $past(msg.data[1]))
      else $error("undervoltage disable not written");
   chk_wd_period: assert property (
      wdr_q[1:0] == 2'b10 |-> wd_limit == 12'd2250)
      else $error("watchdog period wrong");
   chk_wd_restart: assert property (
      wd_restart |=> ms_q == 12'h000 && !watchdog_timeout)
      else $error("watchdog not restarted");
   chk_invalid_frame: assert property (
      frame_end && !len_ok |=> $stable(sel_q) && $stable(prev_addr_q) && $stable(onoff_q))
      else $error("invalid frame changed state");
   chk_ret_freeze: assert property (
      state_q == HSS_FRAME && !cs_s2_q |=> $stable(ret_q))
      else $error("return word moved during frame");
   chk_ret_header: assert property (
      commit ##1 state_q == HSS_IDLE && cs_s2_q |=> ret_q.addr == $past(addr, 2))
      else $error("address echo wrong");

   cov_valid_frame: cover property (commit);
   cov_invalid_frame: cover property (frame_end && !len_ok);
   cov_wd_timeout: cover property ($rose(watchdog_timeout));

endmodule

// >>> verilog/hss_spi_link.sv
// link-side shifter running on the serial clock
`timescale 1ns/1ps
module hss_spi_link
   import hss_pkg::*;
(
   // link pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so_o,
   output logic so_oe,
   // system side
   input wire logic rst,
   input wire hss_ret_t ret_word,
   output logic [WORD_BITS-1:0] rx_word,
   output logic len_ok,
   output logic frame_tgl
);

   // ------------------------------------------------------------
   // frame counters, cleared while chip select is high
   // ------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic seen_q, seen_d;
   logic past16_q, past16_d;
   logic [WORD_BITS-1:0] rx_q, rx_d;
   logic len_ok_q, len_ok_d;
   logic tgl_q, tgl_d;

   always_comb begin
      cnt_d = cnt_q + 4'h1;
      seen_d = 1'b1;
      past16_d = past16_q | (cnt_q == 4'hf);
      rx_d = {rx_q[WORD_BITS-2:0], si};
      len_ok_d = (cnt_d == 4'h0);
      tgl_d = tgl_q ^ ~seen_q;
   end

   // clock stops outside frames, so the frame edge itself clears these
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_q <= 4'h0;
         seen_q <= 1'b0;
         past16_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         seen_q <= seen_d;
         past16_q <= past16_d;
      end
   end

   // these must outlive the frame so the system side can read them
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         rx_q <= 16'h0000;
         len_ok_q <= 1'b0;
         tgl_q <= 1'b0;
      end else begin
         rx_q <= rx_d;
         len_ok_q <= len_ok_d;
         tgl_q <= tgl_d;
      end
   end

   // ------------------------------------------------------------
   // serial output
   // ------------------------------------------------------------
   assign so_o = past16_q ? rx_q[WORD_BITS-1] : ret_word[~cnt_q];
   assign so_oe = ~cs_n;
   assign rx_word = rx_q;
   assign len_ok = len_ok_q;
   assign frame_tgl = tgl_q;

endmodule
